//--- core/ucp_pkg.sv
// Package: register map, fields and constants of the control pipe and pipe window block
`default_nettype none
package ucp_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int NUM_PIPES = 9;

	// ***************************************************
	// Register offsets
	// ***************************************************
	localparam logic [7:0] OFF_CTRL_PIPE = 8'h60;
	localparam logic [7:0] OFF_PIPE_SEL = 8'h64;
	localparam logic [7:0] OFF_PIPE_CFG = 8'h68;
	localparam logic [7:0] OFF_LINK_STAT = 8'h70;

	// ***************************************************
	// Control pipe register fields
	// ***************************************************
	localparam int BIT_BUF_READY = 15;
	localparam int BIT_TOG_DATA0 = 8;
	localparam int BIT_TOG_DATA1 = 7;
	localparam int BIT_TOG_MON = 6;
	localparam int BIT_BUSY = 5;
	localparam int BIT_STAT_CPL = 2;
	localparam int BIT_RESP_LO = 0;

	// ***************************************************
	// Pipe configuration fields
	// ***************************************************
	localparam int BIT_TYPE_LO = 14;
	localparam int BIT_READY_TIMING = 10;
	localparam int BIT_DBL_BUF = 9;
	localparam int BIT_CONT_MODE = 8;
	localparam int BIT_NAK_END = 7;
	localparam int BIT_DIR = 4;
	localparam int BIT_EP_LO = 0;
	localparam logic [15:0] CFG_WR_MASK = 16'hc79f;

	// ***************************************************
	// Reset values and pipe selector limits
	// ***************************************************
	localparam logic [3:0] RST_PIPE_SEL = 4'h0;
	localparam logic [15:0] RST_PIPE_CFG = 16'h0000;
	localparam logic RST_TOG_MON = 1'b1;
	localparam logic [3:0] SEL_NONE = 4'h0;
	localparam logic [3:0] SEL_MAX = 4'h9;

	typedef enum logic [1:0] {
		UCP_RESP_NAK = 2'b00,
		UCP_RESP_BUF = 2'b01,
		UCP_RESP_STALL = 2'b10,
		UCP_RESP_STALL2 = 2'b11
	} ucp_resp_t;

	typedef enum logic [1:0] {
		UCP_TYPE_OFF = 2'b00,
		UCP_TYPE_BULK = 2'b01,
		UCP_TYPE_INTR = 2'b10,
		UCP_TYPE_ISO = 2'b11
	} ucp_type_t;

	// Register bus request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} ucp_bus_req_t;

	// Link-side events from the protocol engine
	typedef struct packed {
		logic setup_ok;
		logic set_address;
		logic xact_start;
		logic xact_done;
		logic xact_ok;
		logic pid_mismatch;
		logic status_stage;
		logic over_maxp;
		logic seq_error;
		logic bus_reset;
		logic buf_access;
		logic [3:0] pipe;
		logic rx_data;
		logic tx_data;
		logic read_done;
		logic transfer_end;
	} ucp_link_ev_t;

	// Pipe configuration as seen by the data path
	typedef struct packed {
		ucp_type_t ptype;
		logic ready_timing;
		logic dbl_buf;
		logic cont_mode;
		logic nak_end;
		logic dir;
		logic [3:0] ep;
	} ucp_pipe_cfg_t;
endpackage
`default_nettype wire

//--- core/ucp_ctrl.sv
// Control pipe control register, pipe window selector and per-pipe configuration
`default_nettype none

module ucp_ctrl
	import ucp_pkg::*;
#(
	parameter int PIPES = NUM_PIPES
) (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire ucp_bus_req_t i_bus,
	output logic [DATA_W-1:0] o_rdata,
	input wire ucp_link_ev_t i_ev,
	input wire logic i_fifo_dir_sel,
	input wire logic i_setup_flag_clr,
	output logic [1:0] o_ctrl_resp,
	output logic o_ctrl_toggle,
	output logic o_status_ack,
	output logic o_status_zlp,
	output logic o_auto_addr,
	output logic o_buffer_ready_event,
	output logic [PIPES-1:0] o_pipe_nak_req,
	output ucp_pipe_cfg_t o_cur_cfg
);

	// ***************************************************
	// Helpers
	// ***************************************************
	function automatic logic sel_valid(input logic [3:0] s);
		return (s != SEL_NONE) && (s <= SEL_MAX);
	endfunction

	function automatic logic [3:0] pipe_idx(input logic [3:0] s);
		return 4'(s - 4'h1);
	endfunction

	logic wr_ctrl;
	logic wr_sel;
	logic wr_cfg;
	logic rd_any;
	assign wr_ctrl = i_bus.wr && (i_bus.addr == OFF_CTRL_PIPE);
	assign wr_sel = i_bus.wr && (i_bus.addr == OFF_PIPE_SEL);
	assign wr_cfg = i_bus.wr && (i_bus.addr == OFF_PIPE_CFG);
	assign rd_any = i_bus.rd;

	// ***************************************************
	// Control pipe state
	// ***************************************************
	logic setup_flag_q;
	logic tog_mon_q;
	logic busy_q;
	logic stat_cpl_q;
	logic [1:0] resp_q;
	logic [1:0] resp_d;
	logic buf_ready_q;
	logic addr_auto_q;
	logic sel_ok;

	// Setup-received flag: hardware set wins over software clear
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			setup_flag_q <= 1'b0;
		end else if (i_ev.setup_ok) begin
			setup_flag_q <= 1'b1;
		end else if (i_setup_flag_clr) begin
			setup_flag_q <= 1'b0;
		end
	end

	// Automatic SET_ADDRESS handling window
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			addr_auto_q <= 1'b0;
		end else if (i_ev.bus_reset) begin
			addr_auto_q <= 1'b0;
		end else if (i_ev.set_address) begin
			addr_auto_q <= 1'b1;
		end else if (addr_auto_q && i_ev.status_stage && i_ev.xact_done && i_ev.xact_ok) begin
			addr_auto_q <= 1'b0;
		end
	end

	// Sequence toggle expectation
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			tog_mon_q <= RST_TOG_MON;
		end else if (i_ev.setup_ok) begin
			tog_mon_q <= 1'b1;
		end else if (wr_ctrl && i_bus.wdata[BIT_TOG_DATA0]) begin
			tog_mon_q <= 1'b0;
		end else if (wr_ctrl && i_bus.wdata[BIT_TOG_DATA1]) begin
			tog_mon_q <= 1'b1;
		end else if (i_ev.xact_done && i_ev.xact_ok && !i_ev.pid_mismatch && !i_ev.status_stage) begin
			tog_mon_q <= ~tog_mon_q;
		end
	end

	// Pipe busy across one transaction
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			busy_q <= 1'b0;
		end else if (i_ev.xact_start) begin
			busy_q <= 1'b1;
		end else if (i_ev.xact_done || i_ev.bus_reset) begin
			busy_q <= 1'b0;
		end
	end

	// Status-complete request
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			stat_cpl_q <= 1'b0;
		end else if (i_ev.setup_ok || i_ev.bus_reset) begin
			stat_cpl_q <= 1'b0;
		end else if (wr_ctrl && i_bus.wdata[BIT_STAT_CPL] && !setup_flag_q) begin
			stat_cpl_q <= 1'b1;
		end else if (i_ev.status_stage && i_ev.xact_done && i_ev.xact_ok) begin
			stat_cpl_q <= 1'b0;
		end
	end

	// Response field: hardware events take priority over software
	always_comb begin
		resp_d = resp_q;
		if (wr_ctrl && !setup_flag_q) begin
			resp_d = i_bus.wdata[BIT_RESP_LO +: 2];
		end
		if (i_ev.over_maxp && resp_q == UCP_RESP_BUF) begin
			resp_d = UCP_RESP_STALL2;
		end
		if (i_ev.seq_error) begin
			resp_d = UCP_RESP_STALL;
		end
		if (i_ev.setup_ok) begin
			resp_d = UCP_RESP_NAK;
		end
		if (i_ev.bus_reset) begin
			resp_d = UCP_RESP_NAK;
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			resp_q <= UCP_RESP_NAK;
		end else begin
			resp_q <= resp_d;
		end
	end

	// Buffer accessibility, registered from the buf_access link event
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			buf_ready_q <= 1'b0;
		end else begin
			buf_ready_q <= i_ev.buf_access;
		end
	end

	// Outputs toward the protocol engine
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_ctrl_resp <= UCP_RESP_NAK;
			o_ctrl_toggle <= RST_TOG_MON;
			o_auto_addr <= 1'b0;
		end else begin
			// Bits 1x both decode to STALL
			o_ctrl_resp <= resp_d[1] ? UCP_RESP_STALL : resp_d;
			o_ctrl_toggle <= tog_mon_q;
			o_auto_addr <= addr_auto_q;
		end
	end

	// Status stage answers
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_status_ack <= 1'b0;
			o_status_zlp <= 1'b0;
		end else begin
			// ACK and ZLP both set in the auto-address window or on status complete with BUF response
			o_status_ack <= addr_auto_q || (stat_cpl_q && resp_q == UCP_RESP_BUF);
			o_status_zlp <= addr_auto_q || (stat_cpl_q && resp_q == UCP_RESP_BUF);
		end
	end

	// ***************************************************
	// Pipe window
	// ***************************************************
	logic [3:0] sel_q;
	logic [15:0] cfg_q [PIPES];
	logic [15:0] cur_raw;

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sel_q <= RST_PIPE_SEL;
		end else if (wr_sel) begin
			sel_q <= i_bus.wdata[3:0];
		end
	end

	assign sel_ok = sel_valid(sel_q);
	assign cur_raw = sel_ok ? cfg_q[pipe_idx(sel_q)] : 16'h0000;

	// Only the configuration is windowed
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			for (int i = 0; i < PIPES; i++) begin
				cfg_q[i] <= RST_PIPE_CFG;
			end
		end else if (wr_cfg && sel_ok) begin
			cfg_q[pipe_idx(sel_q)] <= i_bus.wdata & CFG_WR_MASK;
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_cur_cfg <= '0;
		end else begin
			o_cur_cfg.ptype <= ucp_type_t'(cur_raw[BIT_TYPE_LO +: 2]);
			o_cur_cfg.ready_timing <= cur_raw[BIT_READY_TIMING];
			o_cur_cfg.dbl_buf <= cur_raw[BIT_DBL_BUF];
			o_cur_cfg.cont_mode <= cur_raw[BIT_CONT_MODE];
			o_cur_cfg.nak_end <= cur_raw[BIT_NAK_END];
			o_cur_cfg.dir <= cur_raw[BIT_DIR];
			o_cur_cfg.ep <= cur_raw[BIT_EP_LO +: 4];
		end
	end

	// Buffer-ready event and end-of-transfer NAK for the pipe in use
	logic ev_ok;
	logic [15:0] ev_cfg;
	assign ev_ok = sel_valid(i_ev.pipe);
	assign ev_cfg = ev_ok ? cfg_q[pipe_idx(i_ev.pipe)] : 16'h0000;

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_buffer_ready_event <= 1'b0;
		end else if (!ev_ok || ev_cfg[BIT_TYPE_LO +: 2] == UCP_TYPE_OFF) begin
			o_buffer_ready_event <= 1'b0;
		end else if (ev_cfg[BIT_READY_TIMING]) begin
			o_buffer_ready_event <= i_ev.read_done;
		end else begin
			o_buffer_ready_event <= i_ev.rx_data || i_ev.tx_data;
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_pipe_nak_req <= '0;
		end else begin
			for (int i = 0; i < PIPES; i++) begin
				o_pipe_nak_req[i] <= ev_ok && (pipe_idx(i_ev.pipe) == 4'(i)) && i_ev.transfer_end
					&& cfg_q[i][BIT_NAK_END] && !cfg_q[i][BIT_DIR];
			end
		end
	end

	// ***************************************************
	// Read data, one cycle after the strobe
	// ***************************************************
	logic [15:0] ctrl_view;
	always_comb begin
		ctrl_view = 16'h0000;
		ctrl_view[BIT_BUF_READY] = buf_ready_q;
		ctrl_view[BIT_TOG_MON] = tog_mon_q;
		ctrl_view[BIT_BUSY] = busy_q;
		ctrl_view[BIT_RESP_LO +: 2] = resp_q;
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_rdata <= '0;
		end else if (rd_any) begin
			unique case (i_bus.addr)
				OFF_CTRL_PIPE: o_rdata <= ctrl_view;
				OFF_PIPE_SEL: o_rdata <= {12'h000, sel_q};
				OFF_PIPE_CFG: o_rdata <= cur_raw;
				OFF_LINK_STAT: o_rdata <= {14'h0000, i_fifo_dir_sel, setup_flag_q};
				default: o_rdata <= 16'h0000;
			endcase
		end else begin
			o_rdata <= '0;
		end
	end

endmodule
`default_nettype wire

//--- tb/ucp_ctrl_sva.sv
// Assertion checker for the control pipe block
`default_nettype none
module ucp_ctrl_sva
	import ucp_pkg::*;
#(
	parameter int PIPES = NUM_PIPES
) (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire ucp_bus_req_t i_bus,
	input wire logic [DATA_W-1:0] o_rdata,
	input wire ucp_link_ev_t i_ev,
	input wire logic [1:0] o_ctrl_resp,
	input wire logic o_ctrl_toggle,
	input wire logic o_buffer_ready_event,
	input wire logic [PIPES-1:0] o_pipe_nak_req
);
	timeunit 1ns;
	timeprecision 1ps;
	logic rdy_src;
	assign rdy_src = i_ev.rx_data | i_ev.tx_data | i_ev.read_done;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);
	// ********************
	// Properties
	// ********************
	property p_rd_ctrl;
		$past(i_bus.rd) && $past(i_bus.addr) == OFF_CTRL_PIPE |-> o_rdata[8:7] == 2'h0 && o_rdata[4:2] == 3'h0;
	endproperty
	a_rd_ctrl: assert property (p_rd_ctrl) else $error("write-only bits read nonzero");
	property p_tog_clr;
		i_bus.wr && i_bus.addr == OFF_CTRL_PIPE && i_bus.wdata[8] && !i_ev.setup_ok |-> ##2 !o_ctrl_toggle;
	endproperty
	a_tog_clr: assert property (p_tog_clr) else $error("toggle not forced to zero");
	property p_tog_setup;
		i_ev.setup_ok |-> ##2 o_ctrl_toggle;
	endproperty
	a_tog_setup: assert property (p_tog_setup) else $error("toggle not one after setup");
	property p_resp_code;
		o_ctrl_resp != 2'h3;
	endproperty
	a_resp_code: assert property (p_resp_code) else $error("bad response code");
	property p_setup_nak;
		i_ev.setup_ok |=> o_ctrl_resp == 2'h0;
	endproperty
	a_setup_nak: assert property (p_setup_nak) else $error("setup left response");
	property p_reset_nak;
		i_ev.bus_reset |=> o_ctrl_resp == 2'h0;
	endproperty
	a_reset_nak: assert property (p_reset_nak) else $error("bus reset left response");
	property p_seq_stall;
		i_ev.seq_error && !i_ev.setup_ok && !i_ev.bus_reset |=> o_ctrl_resp == 2'h2;
	endproperty
	a_seq_stall: assert property (p_seq_stall) else $error("no stall on sequence error");
	property p_maxp;
		i_ev.over_maxp && o_ctrl_resp == 2'h1 && !i_ev.seq_error && !i_ev.setup_ok && !i_ev.bus_reset
			|=> o_ctrl_resp == 2'h2;
	endproperty
	a_maxp: assert property (p_maxp) else $error("no stall on oversize data");
	property p_bre;
		o_buffer_ready_event |-> $past(rdy_src) || $past(rdy_src, 2);
	endproperty
	a_bre: assert property (p_bre) else $error("ready event without cause");
	property p_nak;
		|o_pipe_nak_req |-> $onehot(o_pipe_nak_req) && ($past(i_ev.transfer_end) || $past(i_ev.transfer_end, 2));
	endproperty
	a_nak: assert property (p_nak) else $error("nak request without transfer end");
	c_setup: cover property (i_ev.setup_ok);
	c_bre: cover property (o_buffer_ready_event);
	c_nak: cover property (|o_pipe_nak_req);
endmodule
bind ucp_ctrl ucp_ctrl_sva #(.PIPES(PIPES)) ucp_ctrl_sva_inst (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
	.i_bus(i_bus), .o_rdata(o_rdata), .i_ev(i_ev), .o_ctrl_resp(o_ctrl_resp), .o_ctrl_toggle(o_ctrl_toggle),
	.o_buffer_ready_event(o_buffer_ready_event), .o_pipe_nak_req(o_pipe_nak_req));
`default_nettype wire

//--- tb/ucp_host_model.sv
// Host side of the link: drives protocol engine events
`default_nettype none
module ucp_host_model
	import ucp_pkg::*;
(
	input wire logic i_mclk,
	output var ucp_link_ev_t o_ev
);
	timeunit 1ns;
	timeprecision 1ps;
	initial o_ev = '0;
	// ********************
	// One-cycle event, access level kept, then idle
	// ********************
	task automatic send(input logic [18:0] m, input int idle);
		@(posedge i_mclk);
		o_ev <= ucp_link_ev_t'(m);
		@(posedge i_mclk);
		o_ev <= ucp_link_ev_t'(m & 19'h00100);
		repeat (idle) @(posedge i_mclk);
	endtask
endmodule
`default_nettype wire

//--- tb/ucp_ctrl_tb.sv
// Self-checking bench for the control pipe block
`default_nettype none
module ucp_ctrl_tb
	import ucp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] CP = OFF_CTRL_PIPE;
	localparam logic [18:0] E_SETUP = 19'h40000, E_ADDR = 19'h20000, E_START = 19'h10000, E_DONE = 19'h08000;
	localparam logic [18:0] E_GOOD = 19'h0c000, E_MISM = 19'h02000, E_STAT = 19'h01000, E_MAXP = 19'h00800;
	localparam logic [18:0] E_SEQ = 19'h00400, E_BRST = 19'h00200, E_ACC = 19'h00100, E_RX = 19'h00008;
	localparam logic [18:0] E_RDN = 19'h00002, E_TEND = 19'h00001;
	logic i_mclk = 1'b0;
	logic i_reset_n = 1'b0;
	logic fdir = 1'b1;
	logic sclr = 1'b0;
	ucp_bus_req_t bus = '0;
	ucp_link_ev_t ev_w;
	logic [15:0] rdata, v;
	logic [1:0] resp;
	logic sack, szlp, aaddr, bre;
	logic [8:0] nakr;
	logic [8:0] nak_seen = '0;
	ucp_pipe_cfg_t cur;
	int bre_n = 0;
	int mismatches = 0;
	int tests_run = 0;
	ucp_ctrl #(.PIPES(NUM_PIPES)) ucp_ctrl_inst (
		.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_bus(bus), .o_rdata(rdata), .i_ev(ev_w),
		.i_fifo_dir_sel(fdir), .i_setup_flag_clr(sclr), .o_ctrl_resp(resp), .o_ctrl_toggle(),
		.o_status_ack(sack), .o_status_zlp(szlp), .o_auto_addr(aaddr), .o_buffer_ready_event(bre),
		.o_pipe_nak_req(nakr), .o_cur_cfg(cur)
	);
	ucp_host_model ucp_host_model_inst (.i_mclk(i_mclk), .o_ev(ev_w));
	always #25 i_mclk = ~i_mclk;
	always @(posedge i_mclk) begin
		if (bre === 1'b1)
			bre_n <= bre_n + 1;
		if (|nakr)
			nak_seen <= nakr;
	end
	// ********************
	// Access tasks
	// ********************
	task automatic chk(input logic [15:0] s, input logic [15:0] x);
		tests_run++;
		if (s !== x) begin
			mismatches++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, s, x);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_mclk);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge i_mclk);
		bus <= '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] x);
		@(posedge i_mclk);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge i_mclk);
		bus <= '0;
		#1;
		chk(rdata, x);
	endtask
	task automatic ev(input logic [18:0] m);
		ucp_host_model_inst.send(m, 3);
		#1;
	endtask
	task automatic clr();
		@(posedge i_mclk);
		sclr <= 1'b1;
		@(posedge i_mclk);
		sclr <= 1'b0;
	endtask
	task automatic test_done();
		if (mismatches == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#200us;
		mismatches++;
		test_done();
	end
	// ********************
	// Tests
	// ********************
	initial begin
		repeat (12) @(posedge i_mclk);
		i_reset_n <= 1'b1;
		rd(CP, 16'h0040);
		rd(OFF_PIPE_SEL, 16'h0000);
		rd(8'h7e, 16'h0000);
		wr(CP, 16'h0100);
		rd(CP, 16'h0000);
		wr(CP, 16'h0080);
		rd(CP, 16'h0040);
		for (int i = 0; i < 4; i++) begin
			wr(CP, 16'(i));
			rd(CP, 16'h0040 | 16'(i));
			chk({14'h0000, resp}, (i > 1) ? 16'h0002 : 16'(i));
		end
		wr(CP, 16'h0100);
		ev(E_GOOD);
		rd(CP, 16'h0040);
		ev(E_GOOD | E_MISM);
		rd(CP, 16'h0040);
		ev(E_GOOD | E_STAT);
		rd(CP, 16'h0040);
		ev(E_GOOD);
		rd(CP, 16'h0000);
		ev(E_START);
		rd(CP, 16'h0020);
		ev(E_DONE);
		rd(CP, 16'h0000);
		ucp_host_model_inst.send(E_ACC, 0);
		rd(CP, 16'h8000);
		ev(19'h00000);
		rd(OFF_LINK_STAT, 16'h0002);
		@(posedge i_mclk);
		fdir <= 1'b0;
		rd(OFF_LINK_STAT, 16'h0000);
		wr(CP, 16'h0001);
		ev(E_SETUP);
		rd(CP, 16'h0040);
		wr(CP, 16'h0005);
		rd(CP, 16'h0040);
		chk({15'h0000, sack | szlp}, 16'h0000);
		clr();
		wr(CP, 16'h0005);
		rd(CP, 16'h0041);
		chk({15'h0000, sack | szlp}, 16'h0001);
		ev(E_SETUP);
		chk({15'h0000, sack | szlp}, 16'h0000);
		clr();
		wr(CP, 16'h0001);
		ev(E_MAXP);
		rd(CP, 16'h0043);
		wr(CP, 16'h0001);
		ev(E_SEQ);
		chk({14'h0000, resp}, 16'h0002);
		ev(E_BRST);
		chk({14'h0000, resp}, 16'h0000);
		wr(OFF_PIPE_SEL, 16'h0000);
		wr(OFF_PIPE_CFG, 16'hffff);
		rd(OFF_PIPE_CFG, 16'h0000);
		chk({5'h00, cur}, 16'h0000);
		for (int p = 1; p < 10; p++) begin
			wr(OFF_PIPE_SEL, 16'(p));
			wr(OFF_PIPE_CFG, {4{4'(p)}});
		end
		for (int p = 1; p < 10; p++) begin
			v = {4{4'(p)}} & CFG_WR_MASK;
			wr(OFF_PIPE_SEL, 16'(p));
			rd(OFF_PIPE_CFG, v);
			chk({5'h00, cur}, {5'h00, v[15:14], v[10:7], v[4:0]});
		end
		wr(OFF_PIPE_SEL, 16'h000a);
		rd(OFF_PIPE_CFG, 16'h0000);
		wr(OFF_PIPE_SEL, 16'h0006);
		wr(OFF_PIPE_CFG, 16'h4080);
		ev(E_RX | 19'h00060);
		ev(E_RDN | 19'h00060);
		chk(16'(bre_n), 16'h0001);
		ev(E_TEND | 19'h00060);
		chk({7'h00, nak_seen}, 16'h0020);
		ev(E_RDN | 19'h00050);
		chk(16'(bre_n), 16'h0002);
		ev(E_RX | 19'h00020);
		chk(16'(bre_n), 16'h0002);
		ev(E_SETUP | E_ADDR);
		chk({15'h0000, aaddr}, 16'h0001);
		test_done();
	end
endmodule
`default_nettype wire
